// File: logic/sci_channel.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module sci_channel
  import sci_pkg::*;
(
  input  wire logic        pclk,                // system clock
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  output logic             irq,                 // level interrupt
  output logic             serial_clock_pin,    // sync clock out
  output logic             serial_transmit_pin, // serial data out
  input  wire logic        serial_receive_pin,  // serial data in
  output logic             master_request_line, // request out
  input  wire logic        slave_request_line   // request in
);
  import sci_pkg::*;

  // ----------------------------------------------------------------
  // state and per-cycle strobes
  // ----------------------------------------------------------------
  sci_state_t  st_ff;     // registered state
  sci_state_t  nxt_st;    // next state
  logic        tick;      // baud tick
  logic        rx_evt;    // byte received
  logic        txe_evt;   // transmit data taken
  logic        tend_evt;  // transmission ended
  logic        mpid_evt;  // id character received
  logic        hit;       // mapped address
  logic [31:0] rd_val;    // read mux
  logic [9:0]  rx_new;    // shifter after next sample
  logic        wr_en;     // apb write strobe
  logic        is_sync;   // sync mode
  logic        is_mp;     // multiprocessor format
  logic        te;        // transmitter on
  logic        re;        // receiver on

  assign wr_en   = psel & penable & pwrite;
  assign is_sync = st_ff.mode[SCI_MODE_SYNC];
  assign is_mp   = st_ff.mode[SCI_MODE_MP] & ~is_sync;
  assign te      = st_ff.ctrl[SCI_CTRL_TE];
  assign re      = st_ff.ctrl[SCI_CTRL_RE];
  assign rx_new  = {serial_receive_pin, st_ff.rx_shift[9:1]};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st   = st_ff;
    tick     = 1'b0;
    rx_evt   = 1'b0;
    txe_evt  = 1'b0;
    tend_evt = 1'b0;
    mpid_evt = 1'b0;
    hit      = 1'b1;
    rd_val   = 32'h0000_0000;

    // read decode
    if (paddr == SCI_MODE_OFS)
      rd_val = {24'h00_0000, st_ff.mode};
    else if (paddr == SCI_CTRL_OFS)
      rd_val = {24'h00_0000, st_ff.ctrl};
    else if (paddr == SCI_STAT_OFS)
      rd_val = {24'h00_0000, st_ff.transmit_data_empty_flag, st_ff.receive_full_flag, 3'h0, st_ff.tend, st_ff.mpb, st_ff.multiproc_bit_transfer};
    else if (paddr == SCI_RDATA_OFS)
      rd_val = {24'h00_0000, st_ff.receive_data_reg};
    else if (paddr == SCI_TDATA_OFS)
      rd_val = {24'h00_0000, st_ff.transmit_data_reg};
    else if (paddr == SCI_BAUD_OFS)
      rd_val = {24'h00_0000, st_ff.baud_divisor_reg};
    else if (paddr == SCI_IRQ_STAT_OFS)
      rd_val = {28'h000_0000, st_ff.irq_stat};
    else if (paddr == SCI_IRQ_MASK_OFS)
      rd_val = {28'h000_0000, st_ff.irq_mask};
    else if (paddr == SCI_PORT_OFS)
      rd_val = {27'h000_0000, slave_request_line, 3'h0, st_ff.req_out};
    else
      hit = 1'b0;

    // read data captured in the setup cycle
    if (psel && !penable)
      nxt_st.prdata = rd_val;

    // register writes
    if (wr_en)
    begin
      if (paddr == SCI_MODE_OFS)
        nxt_st.mode = pwdata[7:0];
      else if (paddr == SCI_CTRL_OFS)
        nxt_st.ctrl = pwdata[7:0];
      else if (paddr == SCI_STAT_OFS)
      begin
        nxt_st.transmit_data_empty_flag = st_ff.transmit_data_empty_flag & pwdata[SCI_STAT_TRANSMIT_DATA_EMPTY_FLAG];
        nxt_st.receive_full_flag = st_ff.receive_full_flag & pwdata[SCI_STAT_RECEIVE_FULL_FLAG];
        if (st_ff.transmit_data_empty_flag && !pwdata[SCI_STAT_TRANSMIT_DATA_EMPTY_FLAG])
          nxt_st.tend = 1'b0;
        nxt_st.multiproc_bit_transfer = pwdata[SCI_STAT_MULTIPROC_BIT_TRANSFER];
      end
      else if (paddr == SCI_TDATA_OFS)
        nxt_st.transmit_data_reg = pwdata[7:0];
      else if (paddr == SCI_BAUD_OFS)
        nxt_st.baud_divisor_reg = pwdata[7:0];
      else if (paddr == SCI_IRQ_STAT_OFS)
        nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[3:0];
      else if (paddr == SCI_IRQ_MASK_OFS)
        nxt_st.irq_mask = pwdata[3:0];
      else if (paddr == SCI_PORT_OFS)
        nxt_st.req_out = pwdata[SCI_PORT_REQO];
    end

    if (!(te || re))
      nxt_st.brg_cnt = st_ff.baud_divisor_reg;
    else if (st_ff.brg_cnt == 8'h00)
    begin
      tick           = 1'b1;
      nxt_st.brg_cnt = st_ff.baud_divisor_reg;
    end
    else
      nxt_st.brg_cnt = st_ff.brg_cnt - 8'h01;

    // transmitter, also runs the sync receive side
    if (!te)
    begin
      nxt_st.tx_st = SCI_TX_IDLE;
      nxt_st.txd   = 1'b1;
      nxt_st.sclk  = 1'b1;
    end
    else
    begin
      case (st_ff.tx_st)
        SCI_TX_IDLE:
        begin
          if (!st_ff.transmit_data_empty_flag)
          begin
            nxt_st.tx_st  = SCI_TX_BITS;
            nxt_st.transmit_data_empty_flag   = 1'b1;
            nxt_st.tend   = 1'b0;
            nxt_st.tx_sub = 4'h0;
            txe_evt       = 1'b1;
            if (is_sync)
            begin
              nxt_st.tx_shift = {2'h3, st_ff.transmit_data_reg};
              nxt_st.tx_left  = SCI_BITS_SYN;
            end
            else
            begin
              nxt_st.txd = 1'b0;
              nxt_st.tx_shift = {1'b1, is_mp ? st_ff.multiproc_bit_transfer : 1'b1, st_ff.transmit_data_reg};
              nxt_st.tx_left  = is_mp ? SCI_BITS_MP : SCI_BITS_8N1;
            end
          end
        end
        SCI_TX_BITS:
        begin
          if (tick && is_sync)
          begin
            if (st_ff.sclk)
            begin
              // falling edge: next bit out
              nxt_st.sclk     = 1'b0;
              nxt_st.txd      = st_ff.tx_shift[0];
              nxt_st.tx_shift = {1'b1, st_ff.tx_shift[9:1]};
            end
            else
            begin
              nxt_st.sclk     = 1'b1;
              nxt_st.rx_shift = rx_new;
              nxt_st.tx_left  = st_ff.tx_left - 4'h1;
              if (st_ff.tx_left == 4'h1)
              begin
                nxt_st.tx_st = SCI_TX_IDLE;
                nxt_st.txd   = 1'b1;
                if (re)
                begin
                  nxt_st.receive_data_reg  = rx_new[9:2];
                  nxt_st.receive_full_flag = 1'b1;
                  rx_evt      = 1'b1;
                end
                if (nxt_st.transmit_data_empty_flag)
                begin
                  nxt_st.tend = 1'b1;
                  tend_evt    = 1'b1;
                end
              end
            end
          end
          else if (tick)
          begin
            nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
            if (st_ff.tx_sub == SCI_OVS_LAST)
            begin
              if (st_ff.tx_left == 4'h0)
              begin
                nxt_st.tx_st = SCI_TX_IDLE;
                if (nxt_st.transmit_data_empty_flag)
                begin
                  nxt_st.tend = 1'b1;
                  tend_evt    = 1'b1;
                end
              end
              else
              begin
                nxt_st.txd      = st_ff.tx_shift[0];
                nxt_st.tx_shift = {1'b1, st_ff.tx_shift[9:1]};
                nxt_st.tx_left  = st_ff.tx_left - 4'h1;
              end
            end
          end
        end
        default:
          nxt_st.tx_st = SCI_TX_IDLE;
      endcase
    end

    // asynchronous receiver
    if (!re || is_sync)
      nxt_st.rx_st = SCI_RX_IDLE;
    else if (tick)
    begin
      case (st_ff.rx_st)
        SCI_RX_IDLE:
        begin
          if (!serial_receive_pin)
          begin
            nxt_st.rx_st  = SCI_RX_START;
            nxt_st.rx_sub = 4'h0;
          end
        end
        SCI_RX_START:
        begin
          nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          if (st_ff.rx_sub == SCI_OVS_MID)
          begin
            nxt_st.rx_sub  = 4'h0;
            nxt_st.rx_left = is_mp ? SCI_BITS_MP : SCI_BITS_8N1;
            nxt_st.rx_st   = serial_receive_pin ? SCI_RX_IDLE : SCI_RX_BITS;
          end
        end
        SCI_RX_BITS:
        begin
          nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          // one bit time after each centre
          if (st_ff.rx_sub == SCI_OVS_LAST)
          begin
            nxt_st.rx_shift = rx_new;
            nxt_st.rx_left  = st_ff.rx_left - 4'h1;
            if (st_ff.rx_left == 4'h1)
            begin
              nxt_st.rx_st = SCI_RX_IDLE;
              // data characters skipped while waiting for an id
              if (!(is_mp && st_ff.ctrl[SCI_CTRL_MPIE] && !rx_new[8]))
              begin
                nxt_st.receive_data_reg  = is_mp ? rx_new[7:0] : rx_new[8:1];
                nxt_st.mpb  = is_mp & rx_new[8];
                nxt_st.receive_full_flag = 1'b1;
                rx_evt      = 1'b1;
                if (is_mp && rx_new[8])
                begin
                  mpid_evt                  = 1'b1;
                  nxt_st.ctrl[SCI_CTRL_MPIE] = 1'b0;
                end
              end
            end
          end
        end
        default:
          nxt_st.rx_st = SCI_RX_IDLE;
      endcase
    end

    // clock idles high outside sync mode
    if (!nxt_st.mode[SCI_MODE_SYNC])
      nxt_st.sclk = 1'b1;

    // events set sticky bits, set wins over clear
    // receive complete event
    if (rx_evt && st_ff.ctrl[SCI_CTRL_RIE])
      nxt_st.irq_stat[SCI_IRQ_RX] = 1'b1;
    if (txe_evt && st_ff.ctrl[SCI_CTRL_TIE])
      nxt_st.irq_stat[SCI_IRQ_TXE] = 1'b1;
    if (tend_evt && st_ff.ctrl[SCI_CTRL_TRANSMIT_END_IRQ_ENABLE])
      nxt_st.irq_stat[SCI_IRQ_TEND] = 1'b1;
    if (mpid_evt && st_ff.ctrl[SCI_CTRL_RIE])
      nxt_st.irq_stat[SCI_IRQ_MPID] = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= SCI_STATE_RST;
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata              = st_ff.prdata;
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~hit;
  assign irq                 = |(st_ff.irq_stat & st_ff.irq_mask);
  assign serial_clock_pin    = st_ff.sclk;
  assign serial_transmit_pin = st_ff.txd;
  // request line driven only from req_out, written through the port register
  assign master_request_line = st_ff.req_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence tx_go;
    te && st_ff.tx_st == SCI_TX_IDLE && !st_ff.transmit_data_empty_flag;
  endsequence

  sequence rx_start_seen;
    re && !is_sync && tick && st_ff.rx_st == SCI_RX_IDLE && !serial_receive_pin;
  endsequence

  sync_clk_idle_a: assert property (!st_ff.mode[SCI_MODE_SYNC] |-> serial_clock_pin)
    else $error("serial clock not idle outside sync mode");
  sync_duplex_a: assert property ((is_sync && st_ff.tx_st == SCI_TX_BITS && tick && !st_ff.sclk)
    |=> serial_clock_pin && st_ff.rx_shift[9] == $past(serial_receive_pin))
    else $error("sync receive not sampled on clock rise");
  mode_write_a: assert property ((wr_en && paddr == SCI_MODE_OFS && pwdata[7:0] == 8'h80)
    |=> is_sync && serial_clock_pin)
    else $error("mode write did not select sync");
  ctrl_write_a: assert property ((wr_en && paddr == SCI_CTRL_OFS && pwdata[7:0] == 8'h70)
    |=> te && re && st_ff.ctrl[SCI_CTRL_RIE])
    else $error("control write did not enable channel");
  baud_tick_a: assert property ((tick && !(wr_en && paddr == SCI_BAUD_OFS))
    |=> st_ff.brg_cnt == st_ff.baud_divisor_reg)
    else $error("baud divider not reloaded");
  tx_load_a: assert property (tx_go |=> st_ff.tx_st == SCI_TX_BITS && st_ff.transmit_data_empty_flag
    && st_ff.tx_shift[7:0] == $past(st_ff.transmit_data_reg))
    else $error("transmit data not loaded");
  tx_frame_a: assert property ((tx_go and !is_sync) |=> !serial_transmit_pin ##0
    st_ff.tx_left == ($past(is_mp) ? SCI_BITS_MP : SCI_BITS_8N1))
    else $error("async frame start wrong");
  tx_mpbit_a: assert property ((tx_go and is_mp) |=> st_ff.tx_shift[8] == $past(st_ff.multiproc_bit_transfer))
    else $error("mp bit not taken from software");
  tx_idle_a: assert property (st_ff.tx_st == SCI_TX_IDLE |-> serial_transmit_pin)
    else $error("transmit line not idle high");
  rx_full_a: assert property (rx_evt |=> st_ff.receive_full_flag)
    else $error("receive full flag not set");
  rx_irq_a: assert property ((rx_evt && st_ff.ctrl[SCI_CTRL_RIE]) |=> st_ff.irq_stat[SCI_IRQ_RX])
    else $error("receive interrupt missing");
  txe_irq_a: assert property ((tx_go and st_ff.ctrl[SCI_CTRL_TIE]) |=> st_ff.irq_stat[SCI_IRQ_TXE])
    else $error("empty interrupt missing");
  tend_evt_a: assert property (tend_evt |=> st_ff.tend && st_ff.tx_st == SCI_TX_IDLE)
    else $error("transmit end not flagged");
  mp_id_a: assert property (mpid_evt |-> is_mp ##1 !st_ff.ctrl[SCI_CTRL_MPIE])
    else $error("id event outside mp mode");
  rx_centre_a: assert property (rx_start_seen |=> st_ff.rx_st == SCI_RX_START && st_ff.rx_sub == 4'h0)
    else $error("start bit not tracked");

endmodule

// File: logic/sci_pkg.sv
package sci_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SCI_MODE_OFS     = 8'h00;  // serial_mode_reg
  localparam logic [7:0] SCI_CTRL_OFS     = 8'h04;  // serial_control_reg
  localparam logic [7:0] SCI_STAT_OFS     = 8'h08;  // serial_status_reg
  localparam logic [7:0] SCI_RDATA_OFS    = 8'h0c;  // receive_data_reg
  localparam logic [7:0] SCI_TDATA_OFS    = 8'h10;  // transmit_data_reg
  localparam logic [7:0] SCI_BAUD_OFS     = 8'h14;  // baud_divisor_reg
  localparam logic [7:0] SCI_IRQ_STAT_OFS = 8'h18;  // sticky event bits
  localparam logic [7:0] SCI_IRQ_MASK_OFS = 8'h1c;  // event mask
  localparam logic [7:0] SCI_PORT_OFS     = 8'h20;  // request lines

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCI_MODE_SYNC  = 7;  // clock-synchronous mode
  localparam int SCI_MODE_MP    = 2;  // multiprocessor format
  localparam int SCI_CTRL_TIE   = 7;  // transmit_empty_irq enable
  localparam int SCI_CTRL_RIE   = 6;  // receive_complete_irq enable
  localparam int SCI_CTRL_TE    = 5;  // transmitter_enable
  localparam int SCI_CTRL_RE    = 4;  // receiver enable
  localparam int SCI_CTRL_MPIE  = 3;  // skip data until an id arrives
  localparam int SCI_CTRL_TRANSMIT_END_IRQ_ENABLE  = 2;  // transmit_end_irq_enable
  localparam int SCI_STAT_TRANSMIT_DATA_EMPTY_FLAG  = 7;  // transmit_data_empty_flag
  localparam int SCI_STAT_RECEIVE_FULL_FLAG  = 6;  // receive_full_flag
  localparam int SCI_STAT_TEND  = 2;  // transmission ended
  localparam int SCI_STAT_MPB   = 1;  // received multiprocessor bit
  localparam int SCI_STAT_MULTIPROC_BIT_TRANSFER  = 0;  // multiproc_bit_transfer
  localparam int SCI_IRQ_RX     = 0;  // receive complete event
  localparam int SCI_IRQ_TXE    = 1;  // transmit data empty event
  localparam int SCI_IRQ_TEND   = 2;  // transmit end event
  localparam int SCI_IRQ_MPID   = 3;  // id character event
  localparam int SCI_PORT_REQO  = 0;  // master_request_line level
  localparam int SCI_PORT_REQI  = 4;  // slave_request_line level

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SCI_MODE_RST = 8'h00;  // async, 8n1
  localparam logic [7:0] SCI_CTRL_RST = 8'h00;  // all disabled
  localparam logic [7:0] SCI_BAUD_RST = 8'hff;  // slowest rate
  localparam logic [3:0] SCI_OVS_LAST = 4'hf;   // 16 ticks per async bit
  localparam logic [3:0] SCI_OVS_MID  = 4'h7;   // start bit centre
  localparam logic [3:0] SCI_BITS_8N1 = 4'h9;   // 8 data + stop
  localparam logic [3:0] SCI_BITS_MP  = 4'ha;   // 8 data + mp bit + stop
  localparam logic [3:0] SCI_BITS_SYN = 4'h8;   // sync byte

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {SCI_TX_IDLE, SCI_TX_BITS} sci_tx_st_t;
  typedef enum logic [1:0] {SCI_RX_IDLE, SCI_RX_START, SCI_RX_BITS} sci_rx_st_t;

  typedef struct packed {
    logic [7:0]  mode;      // serial_mode_reg
    logic [7:0]  ctrl;      // serial_control_reg
    logic        transmit_data_empty_flag;      // transmit_data_empty_flag
    logic        receive_full_flag;      // receive_full_flag
    logic        tend;      // transmit end
    logic        mpb;       // last received mp bit
    logic        multiproc_bit_transfer;      // mp bit to send
    logic [7:0]  receive_data_reg;       // receive_data_reg
    logic [7:0]  transmit_data_reg;       // transmit_data_reg
    logic [7:0]  baud_divisor_reg;       // baud_divisor_reg
    logic [3:0]  irq_stat;  // sticky events
    logic [3:0]  irq_mask;  // event mask
    logic        req_out;   // master_request_line
    logic [7:0]  brg_cnt;   // baud divider
    sci_tx_st_t  tx_st;     // transmitter state
    logic [9:0]  tx_shift;  // outgoing bits
    logic [3:0]  tx_left;   // bits still to send
    logic [3:0]  tx_sub;    // ticks within a bit
    sci_rx_st_t  rx_st;     // receiver state
    logic [9:0]  rx_shift;  // incoming bits
    logic [3:0]  rx_left;   // bits still to take
    logic [3:0]  rx_sub;    // ticks within a bit
    logic        sclk;      // serial clock level
    logic        txd;       // transmit line level
    logic [31:0] prdata;    // read data register
  } sci_state_t;

  localparam sci_state_t SCI_STATE_RST = '{mode: SCI_MODE_RST, ctrl: SCI_CTRL_RST, transmit_data_empty_flag: 1'b1, tend: 1'b1,
                                           baud_divisor_reg: SCI_BAUD_RST, brg_cnt: SCI_BAUD_RST, tx_st: SCI_TX_IDLE,
                                           rx_st: SCI_RX_IDLE, sclk: 1'b1, txd: 1'b1, default: '0};

endpackage

// File: test/sci_channel_test.sv
`timescale 1ns/1ps
module sci_channel_test;
  import sci_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk_w, txd_w, rxd_w, req_o, req_i, sync_on;
  logic [7:0]  sync_byte;
  logic [31:0] rdata_q;
  logic        err_q;
  int          miscompares, comparisons, cyc;
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  sci_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_clock_pin(sclk_w), .serial_transmit_pin(txd_w), .serial_receive_pin(rxd_w),
    .master_request_line(req_o), .slave_request_line(req_i));
  sci_far_end #(.BIT_CLKS(32)) far_u (.pclk(pclk), .sync_mode(sync_on), .serial_clock_pin(sclk_w),
    .serial_transmit_pin(txd_w), .sync_byte(sync_byte), .serial_receive_pin(rxd_w));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    chk("read data", e, rdata_q);
  endtask
  task automatic wait_irq;
    while (irq !== 1'b1) @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    req_i = 1'b1;
    sync_on = 1'b0;
    sync_byte = 8'hff;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(SCI_STAT_OFS, 32'h84);
    rd(SCI_BAUD_OFS, 32'hff);
    chk("slave error mapped", 32'h0, err_q);
    rd(8'h3c, 32'h0);
    chk("slave error unmapped", 32'h1, err_q);
    xfer(1'b1, SCI_BAUD_OFS, 32'h1);
    xfer(1'b1, SCI_IRQ_MASK_OFS, 32'hf);
    xfer(1'b1, SCI_CTRL_OFS, 32'h70);
    far_u.send_char(8'ha5, 1'b0, 1'b0);
    wait_irq;
    rd(SCI_IRQ_STAT_OFS, 32'h1);
    rd(SCI_STAT_OFS, 32'hc4);
    rd(SCI_RDATA_OFS, 32'ha5);
    xfer(1'b1, SCI_IRQ_STAT_OFS, 32'hf);
    xfer(1'b1, SCI_STAT_OFS, 32'hbf);
    rd(SCI_STAT_OFS, 32'h85);
    chk("irq", 32'h0, irq);
    req_i <= 1'b0;
    rd(SCI_PORT_OFS, 32'h0);
    xfer(1'b1, SCI_CTRL_OFS, 32'hf4);
    xfer(1'b1, SCI_TDATA_OFS, 32'h3c);
    xfer(1'b1, SCI_STAT_OFS, 32'h7f);
    repeat (400) @(posedge pclk);
    chk("far async rx", 32'h33c, far_u.got);
    rd(SCI_IRQ_STAT_OFS, 32'h6);
    xfer(1'b1, SCI_IRQ_STAT_OFS, 32'hf);
    xfer(1'b1, SCI_MODE_OFS, 32'h04);
    xfer(1'b1, SCI_TDATA_OFS, 32'h5a);
    xfer(1'b1, SCI_STAT_OFS, 32'h7e);
    repeat (400) @(posedge pclk);
    chk("far mp rx", 32'h25a, far_u.got);
    xfer(1'b1, SCI_IRQ_STAT_OFS, 32'hf);
    far_u.send_char(8'h12, 1'b1, 1'b1);
    wait_irq;
    rd(SCI_IRQ_STAT_OFS, 32'h9);
    rd(SCI_RDATA_OFS, 32'h12);
    xfer(1'b1, SCI_CTRL_OFS, 32'h0);
    req_i <= 1'b1;
    xfer(1'b1, SCI_MODE_OFS, 32'h80);
    sync_on <= 1'b1;
    sync_byte <= 8'hc3;
    xfer(1'b1, SCI_PORT_OFS, 32'h0);
    req_i <= 1'b0;
    rd(SCI_PORT_OFS, 32'h0);
    xfer(1'b1, SCI_PORT_OFS, 32'h1);
    xfer(1'b1, SCI_IRQ_STAT_OFS, 32'hf);
    chk("request out", 32'h1, req_o);
    xfer(1'b1, SCI_CTRL_OFS, 32'h70);
    xfer(1'b1, SCI_TDATA_OFS, 32'h96);
    xfer(1'b1, SCI_STAT_OFS, 32'h3f);
    wait_irq;
    rd(SCI_RDATA_OFS, 32'hc3);
    chk("far sync rx", 32'h96, far_u.got_s);
    chk("clock idle", 32'h1, sclk_w);
    complete_run;
  end
endmodule

// File: test/sci_far_end.sv
`timescale 1ns/1ps
// far-end serial port: async characters both ways, slave of the sync link
module sci_far_end #(
  parameter int BIT_CLKS = 32  // pclk per async bit
) (
  input  wire logic pclk,                // bench clock
  input  wire logic sync_mode,           // act as sync slave
  input  wire logic serial_clock_pin,    // clock from device
  input  wire logic serial_transmit_pin, // data from device
  input  wire logic [7:0] sync_byte,     // sync byte to give
  output logic      serial_receive_pin   // data to device, pulled up
);
  logic [9:0] got;     // async bits after the start bit
  logic [7:0] got_s;   // sync byte taken
  int         sb_idx;  // sync bits given so far
  initial serial_receive_pin = 1'b1;
  initial sb_idx = 0;
  always @(negedge serial_transmit_pin)
  begin
    if (!sync_mode)
    begin
      repeat (BIT_CLKS / 2) @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
        repeat (BIT_CLKS) @(posedge pclk);
        got[i] = serial_transmit_pin;
      end
    end
  end
  // give on fall, line back high after
  always @(negedge serial_clock_pin)
    if (sync_mode)
    begin
      serial_receive_pin <= (sb_idx < 8) ? sync_byte[sb_idx] : 1'b1;
      sb_idx <= sb_idx + 1;
    end
  always @(posedge serial_clock_pin)
    if (sync_mode) got_s <= {serial_transmit_pin, got_s[7:1]};
  // start low, lsb first, stop high
  task automatic send_char(input logic [7:0] d, input logic mp, input logic mp_on);
    logic [10:0] f;
    f = mp_on ? {1'b1, mp, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      serial_receive_pin <= f[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
  endtask
endmodule
